// ===== rtl/hcca_pkg.sv
/*
  Shared constants and types for the counter auxiliary block: register map,
  control bit positions, reset values, error codes and timing figures.
  Assumes a single 200 MHz system clock.
*/
package hcca_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned ONE_MS_NS = 1000000;
  localparam int unsigned CYC_PER_MS = (ONE_MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_IPRESET = 8'h0C;
  localparam logic [7:0] OFS_EPRESET = 8'h10;
  localparam logic [7:0] OFS_CMP0_MIN = 8'h14;
  localparam logic [7:0] OFS_CMP0_MAX = 8'h18;
  localparam logic [7:0] OFS_CMP1_MIN = 8'h1C;
  localparam logic [7:0] OFS_CMP1_MAX = 8'h20;
  localparam logic [7:0] OFS_RING_MIN = 8'h24;
  localparam logic [7:0] OFS_RING_MAX = 8'h28;
  localparam logic [7:0] OFS_UNIT_MS = 8'h2C;
  localparam logic [7:0] OFS_PPR = 8'h30;
  localparam logic [7:0] OFS_POINT_SEL = 8'h34;
  localparam logic [7:0] OFS_STATUS = 8'h38;
  localparam logic [7:0] OFS_COUNT = 8'h3C;
  localparam logic [7:0] OFS_REV_CNT = 8'h40;

  // control register bits
  localparam int unsigned CTRL_CNT_EN = 0;
  localparam int unsigned CTRL_EXT_ALLOW = 2;
  localparam int unsigned CTRL_CMP_EN = 3;
  localparam int unsigned CTRL_REV_EN = 4;
  localparam int unsigned CTRL_LATCH = 5;
  localparam int unsigned CTRL_RING = 6;

  // command register bits, write-one pulses
  localparam int unsigned CMD_IPRESET = 0;
  localparam int unsigned CMD_CB_RESET = 1;
  localparam int unsigned CMD_CMP0_CLR = 2;
  localparam int unsigned CMD_CMP1_CLR = 3;

  // status register bits
  localparam int unsigned STAT_CARRY = 0;
  localparam int unsigned STAT_BORROW = 1;
  localparam int unsigned STAT_EQ0 = 2;
  localparam int unsigned STAT_EQ1 = 3;
  localparam int unsigned STAT_ERR_LSB = 8;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] POINT_SEL_RST = 16'hFFFF;
  localparam logic [31:0] WORD_RST = 32'h00000000;

  // limits and codes
  localparam logic [31:0] LIN_MAX = 32'h7FFFFFFF;
  localparam logic [31:0] LIN_MIN = 32'h80000000;
  localparam logic [15:0] SET_LO = 16'h0001;
  localparam logic [15:0] SET_HI = 16'hEA60;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_MODE = 8'h17;
  localparam logic [7:0] ERR_UNIT = 8'h22;
  localparam logic [7:0] ERR_PPR = 8'h23;
  localparam logic [7:0] NUM_POINTS = 8'h08;

  typedef enum logic [2:0] {
    CMP_LT = 3'h0,
    CMP_LE = 3'h1,
    CMP_EQ = 3'h2,
    CMP_GE = 3'h3,
    CMP_GT = 3'h4,
    CMP_IN = 3'h5,
    CMP_OUT = 3'h6
  } hcca_cmp_mode_t;

  function automatic logic in_setting_range(input logic [15:0] v);
    in_setting_range = (v >= SET_LO) && (v <= SET_HI);
  endfunction

endpackage

// ===== rtl/hcca_cmp.sv
/*
  One compare unit: judges the signed count against its min/max values in
  one of seven modes and registers the result.
  Assumes count and settings come from the same clock domain.
*/
`timescale 1ns/1ps
module hcca_cmp
  import hcca_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // operands and control
  input wire logic [31:0] count_in,
  input wire logic [31:0] lo_in,
  input wire logic [31:0] hi_in,
  input wire logic [7:0] mode_in,
  input wire logic enable_in,
  input wire logic clear_in,
  // result
  output logic match_out
);

  logic match_q;
  logic match_d;
  wire signed [31:0] cnt = $signed(count_in);
  wire signed [31:0] lo = $signed(lo_in);
  wire signed [31:0] hi = $signed(hi_in);
  wire mode_ok = (mode_in <= 8'(CMP_OUT));
  wire [2:0] m = mode_in[2:0];
  wire hit = !mode_ok ? 1'b0 :
             (m == CMP_LT) ? (cnt < lo) :
             (m == CMP_LE) ? (cnt <= lo) :
             (m == CMP_EQ) ? (cnt == lo) :
             (m == CMP_GE) ? (cnt >= lo) :
             (m == CMP_GT) ? (cnt > lo) :
             (m == CMP_IN) ? (cnt >= lo && cnt <= hi) :
             (cnt <= lo || cnt >= hi);

  // equal mode holds its output until software clears it; a new hit wins
  assign match_d = !enable_in ? 1'b0 :
                   (m == CMP_EQ && mode_ok) ? (hit | (match_q & !clear_in)) :
                   hit;

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      match_q <= 1'b0;
    end
    else
    begin
      match_q <= match_d;
    end
  end

  assign match_out = match_q;

endmodule

// ===== rtl/hcca_rev.sv
/*
  Pulses-per-unit-time measurement: counts input pulses over windows of a
  set number of milliseconds and shows the total at each window end.
  Assumes pulse_in is a one-cycle strobe on the same clock.
*/
`timescale 1ns/1ps
module hcca_rev
  import hcca_pkg::*;
#(
  parameter int unsigned CYC_MS = CYC_PER_MS
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // control
  input wire logic enable_in,
  input wire logic [15:0] unit_ms_in,
  input wire logic pulse_in,
  // result
  output logic [31:0] pulses_out
);

  logic [31:0] div_q;
  logic [15:0] ms_q;
  logic [31:0] acc_q;
  logic [31:0] pulses_q;
  wire ms_tick = (div_q == 32'(CYC_MS - 1));
  wire win_end = ms_tick && (ms_q == unit_ms_in - SET_LO);
  wire [31:0] acc_next = acc_q + {31'h00000000, pulse_in};

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      div_q <= WORD_RST;
      ms_q <= 16'h0000;
      acc_q <= WORD_RST;
      pulses_q <= WORD_RST;
    end
    else if (!enable_in)
    begin
      // restart the window cleanly each time measurement is switched on
      div_q <= WORD_RST;
      ms_q <= 16'h0000;
      acc_q <= WORD_RST;
    end
    else
    begin
      div_q <= ms_tick ? WORD_RST : div_q + 32'h00000001;
      ms_q <= win_end ? 16'h0000 : (ms_tick ? ms_q + 16'h0001 : ms_q);
      acc_q <= win_end ? WORD_RST : acc_next;
      if (win_end)
      begin
        pulses_q <= acc_next;
      end
    end
  end

  assign pulses_out = pulses_q;

endmodule

// ===== rtl/hcca_top.sv
/*
  Counter channel auxiliary logic: count register with presets, latch,
  carry/borrow, two compare units, pulse-rate measurement and registers.
  Assumes count_up_in/count_dn_in are decoded one-cycle strobes on clk_in;
  the external preset pin is asynchronous.
*/
`timescale 1ns/1ps
// Overview of operation
// - two independent compare units each judge the 32-bit count.
// - mode codes 0..6 mean lt, le, eq, ge, gt, inside, outside.
// - a mode above 6 reports error code 23.
// - compare works only while compare enable is 1; program sets it after mode.
// - a result reaches an output point only if a point is designated.
// - mode 0 output on while count below the value.
// - mode 1 output on while count at or below the value.
// - mode 2 output on at equality; program clears it by enable or clear.
// - mode 3 output on while count at or above the value.
// - mode 4 output on while count above the value.
// - mode 5 output on while count lies within min..max inclusive.
// - mode 6 output on while count at/below min or at/above max.
// - carry on reaching max linear value, up-counting stops; ring wrap sets carry.
// - borrow on reaching min linear value, down-counting stops; ring wrap sets borrow.
// - carry and borrow hold until the shared reset command clears them.
// - with measurement on, pulses per window are shown at each window end.
// - measurement on with unit time outside 1..60000 ms reports error 34.
// - measurement on with pulses per revolution outside 1..60000 reports 35.
// - with latch on, the count survives restart and resumes from there.
// - internal preset command loads the internal preset value.
// - the preset pin, when allowed, loads the external preset value.
// - after linear carry up-count blocks; after borrow down-count blocks.
module hcca_top
  import hcca_pkg::*;
#(
  parameter int unsigned CYC_MS = CYC_PER_MS
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // counting events
  input wire logic count_up_in,
  input wire logic count_dn_in,
  input wire logic restart_in,
  input wire logic external_preset_input_ch0_in,
  // results
  output logic [7:0] compare_output_points_out,
  output logic [31:0] count_value_out,
  output logic carry_flag_out,
  output logic borrow_flag_out,
  output logic [7:0] error_code_out
);

  logic [7:0] ctrl_q;
  logic [15:0] mode_q;
  logic [31:0] ipre_q;
  logic [31:0] epre_q;
  logic [31:0] c0_min_q;
  logic [31:0] c0_max_q;
  logic [31:0] c1_min_q;
  logic [31:0] c1_max_q;
  logic [31:0] ring_min_q;
  logic [31:0] ring_max_q;
  logic [15:0] unit_q;
  logic [15:0] ppr_q;
  logic [15:0] psel_q;
  logic [31:0] count_q;
  logic [31:0] count_d;
  logic carry_q;
  logic borrow_q;
  logic [7:0] err_q;
  logic [7:0] pts_q;
  logic [7:0] pts_d;
  logic [31:0] rdata_q;
  logic [2:0] pin_q;
  logic pin_stable_q;
  logic m0;
  logic m1;
  logic [31:0] rev_cnt;

  // write decode
  wire wr_ctrl = wr_in && (addr_in == OFS_CTRL);
  wire wr_cmd = wr_in && (addr_in == OFS_CMD);
  wire cmd_ipre = wr_cmd && wdata_in[CMD_IPRESET];
  wire cmd_cb_rst = wr_cmd && wdata_in[CMD_CB_RESET];
  wire cmd_c0_clr = wr_cmd && wdata_in[CMD_CMP0_CLR];
  wire cmd_c1_clr = wr_cmd && wdata_in[CMD_CMP1_CLR];

  // preset pin: three stages, a change counts once stages two and three agree
  wire pin_agree = (pin_q[1] == pin_q[2]);
  wire pin_rise = pin_agree && pin_q[2] && !pin_stable_q;

  // count control
  wire ring = ctrl_q[CTRL_RING];
  wire cnt_en = ctrl_q[CTRL_CNT_EN];
  wire ld_int = cmd_ipre;
  wire ld_ext = pin_rise && ctrl_q[CTRL_EXT_ALLOW];
  wire clr_run = restart_in && !ctrl_q[CTRL_LATCH];
  wire any_load = ld_int || ld_ext || clr_run;
  wire at_top = (count_q == LIN_MAX);
  wire at_bot = (count_q == LIN_MIN);
  wire up_ok = ring || !(carry_q || at_top);
  wire dn_ok = ring || !(borrow_q || at_bot);
  wire step_up = cnt_en && count_up_in && !count_dn_in && up_ok && !any_load;
  wire step_dn = cnt_en && count_dn_in && !count_up_in && dn_ok && !any_load;
  wire ring_top = ring && (count_q == ring_max_q);
  wire ring_bot = ring && (count_q == ring_min_q);
  wire carry_set = step_up && (ring ? ring_top : (count_q == LIN_MAX - 32'h00000001));
  wire borrow_set = step_dn && (ring ? ring_bot : (count_q == LIN_MIN + 32'h00000001));

  // only the preset command, the preset pin or restart may move the count besides stepping
  assign count_d = ld_int ? ipre_q :
                   ld_ext ? epre_q :
                   clr_run ? WORD_RST :
                   step_up ? (ring_top ? ring_min_q : count_q + 32'h00000001) :
                   step_dn ? (ring_bot ? ring_max_q : count_q - 32'h00000001) :
                   count_q;

  // errors, mode error first
  wire mode_bad = (mode_q[7:0] > 8'(CMP_OUT)) || (mode_q[15:8] > 8'(CMP_OUT));
  wire rev_en = ctrl_q[CTRL_REV_EN];
  wire unit_bad = rev_en && !in_setting_range(unit_q);
  wire ppr_bad = rev_en && !in_setting_range(ppr_q);
  wire [7:0] err_d = mode_bad ? ERR_MODE :
                     unit_bad ? ERR_UNIT :
                     ppr_bad ? ERR_PPR :
                     ERR_NONE;

  // the two compare units share the count and the compare enable bit but nothing else
  hcca_cmp u_cmp0 (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .count_in(count_q),
    .lo_in(c0_min_q),
    .hi_in(c0_max_q),
    .mode_in(mode_q[7:0]),
    .enable_in(ctrl_q[CTRL_CMP_EN]),
    .clear_in(cmd_c0_clr),
    .match_out(m0)
  );

  hcca_cmp u_cmp1 (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .count_in(count_q),
    .lo_in(c1_min_q),
    .hi_in(c1_max_q),
    .mode_in(mode_q[15:8]),
    .enable_in(ctrl_q[CTRL_CMP_EN]),
    .clear_in(cmd_c1_clr),
    .match_out(m1)
  );

  hcca_rev #(
    .CYC_MS(CYC_MS)
  ) u_rev (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .enable_in(rev_en && !unit_bad && !ppr_bad),
    .unit_ms_in(unit_q),
    .pulse_in(cnt_en && (count_up_in ^ count_dn_in)),
    .pulses_out(rev_cnt)
  );

  // a designation at or above the point count means no output point
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      pts_d[i] = (m0 && psel_q[7:0] == 8'(i)) || (m1 && psel_q[15:8] == 8'(i));
    end
  end

  // read mux
  wire [31:0] status = {16'h0000, err_q, 4'h0, m1, m0, borrow_q, carry_q};
  wire [31:0] rdata_d = (addr_in == OFS_CTRL) ? {24'h000000, ctrl_q} :
                        (addr_in == OFS_MODE) ? {16'h0000, mode_q} :
                        (addr_in == OFS_IPRESET) ? ipre_q :
                        (addr_in == OFS_EPRESET) ? epre_q :
                        (addr_in == OFS_CMP0_MIN) ? c0_min_q :
                        (addr_in == OFS_CMP0_MAX) ? c0_max_q :
                        (addr_in == OFS_CMP1_MIN) ? c1_min_q :
                        (addr_in == OFS_CMP1_MAX) ? c1_max_q :
                        (addr_in == OFS_RING_MIN) ? ring_min_q :
                        (addr_in == OFS_RING_MAX) ? ring_max_q :
                        (addr_in == OFS_UNIT_MS) ? {16'h0000, unit_q} :
                        (addr_in == OFS_PPR) ? {16'h0000, ppr_q} :
                        (addr_in == OFS_POINT_SEL) ? {16'h0000, psel_q} :
                        (addr_in == OFS_STATUS) ? status :
                        (addr_in == OFS_COUNT) ? count_q :
                        (addr_in == OFS_REV_CNT) ? rev_cnt :
                        WORD_RST;

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ctrl_q <= CTRL_RST;
      mode_q <= MODE_RST;
      psel_q <= POINT_SEL_RST;
      unit_q <= 16'h0000;
      ppr_q <= 16'h0000;
      {ipre_q, epre_q, ring_min_q, ring_max_q} <= {4{WORD_RST}};
      {c0_min_q, c0_max_q, c1_min_q, c1_max_q} <= {4{WORD_RST}};
    end
    else if (wr_in)
    begin
      ctrl_q <= wr_ctrl ? wdata_in[7:0] : ctrl_q;
      mode_q <= (addr_in == OFS_MODE) ? wdata_in[15:0] : mode_q;
      psel_q <= (addr_in == OFS_POINT_SEL) ? wdata_in[15:0] : psel_q;
      unit_q <= (addr_in == OFS_UNIT_MS) ? wdata_in[15:0] : unit_q;
      ppr_q <= (addr_in == OFS_PPR) ? wdata_in[15:0] : ppr_q;
      ipre_q <= (addr_in == OFS_IPRESET) ? wdata_in : ipre_q;
      epre_q <= (addr_in == OFS_EPRESET) ? wdata_in : epre_q;
      ring_min_q <= (addr_in == OFS_RING_MIN) ? wdata_in : ring_min_q;
      ring_max_q <= (addr_in == OFS_RING_MAX) ? wdata_in : ring_max_q;
      c0_min_q <= (addr_in == OFS_CMP0_MIN) ? wdata_in : c0_min_q;
      c0_max_q <= (addr_in == OFS_CMP0_MAX) ? wdata_in : c0_max_q;
      c1_min_q <= (addr_in == OFS_CMP1_MIN) ? wdata_in : c1_min_q;
      c1_max_q <= (addr_in == OFS_CMP1_MAX) ? wdata_in : c1_max_q;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      count_q <= WORD_RST;
      carry_q <= 1'b0;
      borrow_q <= 1'b0;
      err_q <= ERR_NONE;
      pts_q <= 8'h00;
      rdata_q <= WORD_RST;
      pin_q <= 3'h0;
      pin_stable_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      carry_q <= carry_set || (carry_q && !cmd_cb_rst);
      borrow_q <= borrow_set || (borrow_q && !cmd_cb_rst);
      err_q <= err_d;
      pts_q <= pts_d;
      rdata_q <= rd_in ? rdata_d : WORD_RST;
      pin_q <= {pin_q[1:0], external_preset_input_ch0_in};
      pin_stable_q <= pin_agree ? pin_q[2] : pin_stable_q;
    end
  end

  assign rdata_out = rdata_q;
  assign count_value_out = count_q;
  assign carry_flag_out = carry_q;
  assign borrow_flag_out = borrow_q;
  assign error_code_out = err_q;
  assign compare_output_points_out = pts_q;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  wire no_load = !ld_int && !ld_ext && !clr_run;
  wire lin_up = !ring && cnt_en && count_up_in && !count_dn_in && no_load;
  // helper terms for the end-of-range and stepping checks
  wire lin_dn = !ring && cnt_en && count_dn_in && !count_up_in && no_load;
  // a carry already standing blocks the step, so only a fresh approach must land
  wire lin_near_top = lin_up && !carry_q && (count_q == LIN_MAX - 32'h00000001);
  wire lin_near_bot = lin_dn && !borrow_q && (count_q == LIN_MIN + 32'h00000001);
  wire [31:0] count_inc = count_q + 32'h00000001;
  wire [31:0] count_dec = count_q - 32'h00000001;

  a_carry_holds: assert property (carry_q && !cmd_cb_rst |=> carry_q)
    else $error("carry dropped without reset command");
  a_borrow_clears: assert property (cmd_cb_rst && !borrow_set |=> !borrow_q)
    else $error("borrow not cleared by reset command");
  a_mode_error: assert property (mode_bad |=> err_q == ERR_MODE)
    else $error("bad compare mode not reported as 23");
  a_unit_error: assert property (!mode_bad && unit_bad |=> err_q == ERR_UNIT)
    else $error("bad unit time not reported as 34");
  a_int_preset: assert property (ld_int |=> count_q == $past(ipre_q))
    else $error("internal preset did not load");
  a_ext_preset: assert property (ld_ext && !ld_int |=> count_q == $past(epre_q))
    else $error("external preset did not load");
  a_linear_stop: assert property (lin_up && carry_q |=> $stable(count_q))
    else $error("linear count moved past carry");
  a_linear_carry: assert property (lin_near_top |=> count_q == LIN_MAX && carry_q)
    else $error("linear carry missing at top");
  a_ring_wrap: assert property (step_up && ring_top && !ld_int
    |=> count_q == $past(ring_min_q) && carry_q)
    else $error("ring wrap did not reach minimum with carry");
  a_cmp_off: assert property (!ctrl_q[CTRL_CMP_EN] ##1 !ctrl_q[CTRL_CMP_EN]
    |=> pts_q == 8'h00)
    else $error("compare point on while compare disabled");
  a_no_point: assert property (psel_q == POINT_SEL_RST [*2] |=> pts_q == 8'h00)
    else $error("point driven without designation");
  a_latch_keep: assert property (restart_in && ctrl_q[CTRL_LATCH] && !ld_int && !ld_ext
    && !step_up && !step_dn |=> $stable(count_q))
    else $error("latched count lost on restart");
  a_carry_clears: assert property (cmd_cb_rst && !carry_set |=> !carry_q)
    else $error("carry not cleared by reset command");
  a_borrow_holds: assert property (borrow_q && !cmd_cb_rst |=> borrow_q)
    else $error("borrow dropped without reset command");
  a_ppr_error: assert property (!mode_bad && !unit_bad && ppr_bad |=> err_q == ERR_PPR)
    else $error("bad pulses per revolution not reported as 35");
  a_no_error: assert property (!mode_bad && !unit_bad && !ppr_bad |=> err_q == ERR_NONE)
    else $error("error code shown with valid settings");

  // stepping and loading
  a_linear_borrow: assert property (lin_near_bot |=> count_q == LIN_MIN && borrow_q)
    else $error("linear borrow missing at bottom");
  a_borrow_stop: assert property (lin_dn && borrow_q |=> $stable(count_q))
    else $error("linear count moved past borrow");
  a_ring_wrap_down: assert property (step_dn && ring_bot
    |=> count_q == $past(ring_max_q) && borrow_q)
    else $error("ring wrap did not reach maximum with borrow");
  a_step_up: assert property (step_up && !ring_top |=> count_q == $past(count_inc))
    else $error("up step not registered on next edge");
  a_step_down: assert property (step_dn && !ring_bot |=> count_q == $past(count_dec))
    else $error("down step not registered on next edge");
  a_restart_clear: assert property (clr_run && !ld_int && !ld_ext
    |=> count_q == WORD_RST)
    else $error("count not cleared on restart without latch");
  a_ext_blocked: assert property (pin_rise && !ctrl_q[CTRL_EXT_ALLOW] && !ld_int
    && !clr_run && !step_up && !step_dn |=> $stable(count_q))
    else $error("preset pin loaded while not allowed");

  // point routing
  a_point_zero: assert property (m0 && psel_q[7:0] == 8'h00 |=> pts_q[0])
    else $error("designated point 0 not driven by unit 0");
  a_point_one: assert property (m1 && psel_q[15:8] == 8'h01 |=> pts_q[1])
    else $error("designated point 1 not driven by unit 1");

  c_carry_seen: cover property (carry_set);
  c_borrow_seen: cover property (borrow_set);
  c_ring_wrap: cover property (step_dn && ring_bot);
  c_point_on: cover property (pts_q != 8'h00);
  c_ext_load: cover property (ld_ext);

endmodule

// ===== bench/hcca_enc_model.sv
/*
  Encoder-side model: count strobes, a free pulse train and the preset pin.
  Assumes it shares clk_in with the block and is steered by the bench.
*/
`timescale 1ns/1ps
module hcca_enc_model
(
  // clock
  input wire logic clk_in,
  // pulses and preset pin
  output logic up_out,
  output logic dn_out,
  output logic pin_out
);
  logic up_s;
  logic dn_s;
  logic run;
  logic pin_q;
  logic [1:0] ph_q = 2'h0;
  // a steady train of one strobe every four cycles keeps window totals exact
  assign up_out = up_s | (run & (ph_q == 2'h0));
  assign dn_out = dn_s;
  assign pin_out = pin_q;
  initial
  begin
    up_s = 1'b0;
    dn_s = 1'b0;
    run = 1'b0;
    pin_q = 1'b0;
  end
  always @(posedge clk_in)
  begin
    ph_q <= ph_q + 2'h1;
  end
  task automatic step(input logic down);
    up_s <= ~down;
    dn_s <= down;
    @(posedge clk_in);
    up_s <= 1'b0;
    dn_s <= 1'b0;
    @(posedge clk_in);
  endtask
  // held four cycles so the pin synchroniser sees a clean level
  task automatic preset_pulse;
    pin_q <= 1'b1;
    repeat (4) @(posedge clk_in);
    pin_q <= 1'b0;
    repeat (8) @(posedge clk_in);
  endtask
endmodule

// ===== bench/testbench.sv
/*
  Self-checking bench for the counter auxiliary block: register port tasks,
  carry/borrow, compare modes, presets, latch and pulse-rate windows.
  Assumes hcca_pkg and the encoder model are compiled first.
*/
`timescale 1ns/1ps
module testbench;
  import hcca_pkg::*;
  localparam int unsigned CYC = 10;
  logic clk_in;
  logic arst_n_in;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr, rd, restart;
  logic up, dn, pin;
  logic [31:0] rdata, count, rv;
  logic [7:0] points, err;
  logic carry, borrow;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  always #2.5 clk_in = ~clk_in;
  hcca_top #(.CYC_MS(CYC)) DUT (.clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .count_up_in(up),
    .count_dn_in(dn), .restart_in(restart), .external_preset_input_ch0_in(pin),
    .compare_output_points_out(points), .count_value_out(count), .carry_flag_out(carry),
    .borrow_flag_out(borrow), .error_code_out(err));
  hcca_enc_model enc (.clk_in(clk_in), .up_out(up), .dn_out(dn), .pin_out(pin));
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_errors++;
      close_out;
    end
  end
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    chk_w({31'h0, got}, {31'h0, exp});
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    rv = rdata;
    @(posedge clk_in);
  endtask
  task automatic preset(input logic [31:0] v);
    wr_reg(OFS_IPRESET, v);
    wr_reg(OFS_CMD, 32'h1);
    settle(2);
  endtask
  task automatic pulse_restart;
    restart <= 1'b1;
    @(posedge clk_in);
    restart <= 1'b0;
    settle(3);
  endtask
  function automatic logic cmp_exp(input int m, input logic signed [31:0] c,
    input logic signed [31:0] lo, input logic signed [31:0] hi);
    case (m)
      0: cmp_exp = c < lo;
      1: cmp_exp = c <= lo;
      2: cmp_exp = c == lo;
      3: cmp_exp = c >= lo;
      4: cmp_exp = c > lo;
      5: cmp_exp = c >= lo && c <= hi;
      default: cmp_exp = c <= lo || c >= hi;
    endcase
  endfunction
  initial
  begin
    clk_in = 1'b0;
    arst_n_in = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    restart = 1'b0;
    repeat (4) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    rd_reg(OFS_CTRL);
    chk_w(rv, {24'h0, CTRL_RST});
    rd_reg(OFS_POINT_SEL);
    chk_w(rv, {16'h0, POINT_SEL_RST});
    rd_reg(8'h44);
    chk_w(rv, 32'h0);
    wr_reg(OFS_STATUS, 32'hFFFFFFFF);
    rd_reg(OFS_STATUS);
    chk_w(rv, 32'h0);
    wr_reg(OFS_CTRL, 32'h1);
    preset(32'h7FFFFFFE);
    chk_w(count, 32'h7FFFFFFE);
    enc.step(1'b0);
    settle(2);
    chk_w(count, LIN_MAX);
    chk_b(carry, 1'b1);
    enc.step(1'b0);
    settle(2);
    chk_w(count, LIN_MAX);
    enc.step(1'b1);
    settle(2);
    chk_w(count, 32'h7FFFFFFE);
    chk_b(carry, 1'b1);
    wr_reg(OFS_CMD, 32'h2);
    settle(2);
    chk_b(carry, 1'b0);
    preset(32'h80000001);
    enc.step(1'b1);
    enc.step(1'b1);
    settle(2);
    chk_w(count, LIN_MIN);
    chk_b(borrow, 1'b1);
    enc.step(1'b0);
    settle(2);
    chk_w(count, 32'h80000001);
    // ring range 0x10..0x13 wraps both ways
    wr_reg(OFS_RING_MIN, 32'h10);
    wr_reg(OFS_RING_MAX, 32'h13);
    wr_reg(OFS_CMD, 32'h2);
    preset(32'h13);
    wr_reg(OFS_CTRL, 32'h41);
    enc.step(1'b0);
    settle(2);
    chk_w(count, 32'h10);
    chk_b(carry, 1'b1);
    enc.step(1'b1);
    settle(2);
    chk_w(count, 32'h13);
    chk_b(borrow, 1'b1);
    wr_reg(OFS_CMD, 32'h2);
    wr_reg(OFS_CMP0_MIN, 32'd10);
    wr_reg(OFS_CMP0_MAX, 32'd20);
    wr_reg(OFS_CMP1_MIN, 32'd15);
    wr_reg(OFS_POINT_SEL, 32'h0100);
    for (int m = 0; m < 7; m++)
      for (int i = 0; i < 5; i++)
      begin
        wr_reg(OFS_CTRL, 32'h1);
        wr_reg(OFS_MODE, {16'h0, 8'h4, 8'(m)});
        preset(32'(5 + 5 * i));
        wr_reg(OFS_CTRL, 32'h9);
        settle(4);
        chk_b(points[0], cmp_exp(m, 5 + 5 * i, 10, 20));
        chk_b(points[1], (5 + 5 * i) > 15);
      end
    wr_reg(OFS_CTRL, 32'h1);
    settle(4);
    chk_w({24'h0, points}, 32'h0);
    wr_reg(OFS_POINT_SEL, 32'hFFFF);
    wr_reg(OFS_CTRL, 32'h9);
    settle(4);
    chk_w({24'h0, points}, 32'h0);
    rd_reg(OFS_STATUS);
    chk_b(rv[STAT_EQ0], 1'b1);
    wr_reg(OFS_MODE, 32'h0402);
    preset(32'd10);
    enc.step(1'b0);
    settle(4);
    rd_reg(OFS_STATUS);
    chk_b(rv[STAT_EQ0], 1'b1);
    wr_reg(OFS_CMD, 32'h4);
    settle(4);
    rd_reg(OFS_STATUS);
    chk_b(rv[STAT_EQ0], 1'b0);
    wr_reg(OFS_MODE, 32'h0007);
    settle(3);
    chk_w({24'h0, err}, {24'h0, ERR_MODE});
    wr_reg(OFS_MODE, 32'h0);
    wr_reg(OFS_EPRESET, 32'h1234);
    enc.preset_pulse();
    chk_w(count, 32'd11);
    wr_reg(OFS_CTRL, 32'h5);
    enc.preset_pulse();
    chk_w(count, 32'h1234);
    wr_reg(OFS_CTRL, 32'h21);
    pulse_restart();
    chk_w(count, 32'h1234);
    preset(32'h55);
    chk_w(count, 32'h55);
    wr_reg(OFS_CTRL, 32'h1);
    pulse_restart();
    chk_w(count, 32'h0);
    wr_reg(OFS_UNIT_MS, 32'd2);
    wr_reg(OFS_PPR, 32'd1);
    enc.run <= 1'b1;
    wr_reg(OFS_CTRL, 32'h11);
    settle(70);
    rd_reg(OFS_REV_CNT);
    chk_w(rv, 32'd5);
    enc.run <= 1'b0;
    wr_reg(OFS_UNIT_MS, 32'd0);
    settle(3);
    chk_w({24'h0, err}, {24'h0, ERR_UNIT});
    wr_reg(OFS_UNIT_MS, 32'd2);
    wr_reg(OFS_PPR, 32'hEA61);
    settle(3);
    chk_w({24'h0, err}, {24'h0, ERR_PPR});
    close_out;
  end
endmodule
